// file: pkg/antenna_pkg.sv
// Purpose: Shared constants for the antenna driver automatic control block
// Assumes: 250 MHz pclk, APB register access with 32-bit data
// Notes:   Printed offsets are not multiples of four, so they are register indices
package antenna_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  AUTO_CONTROL_INDEX  = 8'h15;
    localparam logic [7:0]  SOURCE_SELECT_INDEX = 8'h16;
    localparam logic [7:0]  DRIVER_CONTROL_INDEX = 8'h14;
    localparam logic [7:0]  STATUS_INDEX        = 8'h17;
    localparam logic [11:0] AUTO_CONTROL_ADDR   = 12'h054;
    localparam logic [11:0] SOURCE_SELECT_ADDR  = 12'h058;
    localparam logic [11:0] DRIVER_CONTROL_ADDR = 12'h050;
    localparam logic [11:0] STATUS_ADDR         = 12'h05c;

    localparam logic [7:0] AUTO_CONTROL_RESET   = 8'h00;
    localparam logic [7:0] SOURCE_SELECT_RESET  = 8'h10;
    localparam logic [7:0] DRIVER_CONTROL_RESET = 8'h80;
    localparam logic [7:0] AUTO_CONTROL_MASK    = 8'hef;
    localparam logic [7:0] SOURCE_SELECT_MASK   = 8'h3f;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int AUTO_FIELD_OFF_BIT   = 7;
    localparam int FORCE_FULL_DEPTH_BIT = 6;
    localparam int FIELD_WAKE_BIT       = 5;
    localparam int COLLISION_AVOID_BIT  = 3;
    localparam int INITIAL_CHECK_BIT    = 2;
    localparam int DRIVER2_AUTO_BIT     = 1;
    localparam int DRIVER1_AUTO_BIT     = 0;
    localparam int DRIVER_SOURCE_LSB    = 4;
    localparam int INV2_ON_BIT          = 7;
    localparam int INV1_ON_BIT          = 6;
    localparam int INV2_OFF_BIT         = 5;
    localparam int INV1_OFF_BIT         = 4;

    typedef enum logic [1:0] {
        SRC_TRISTATE = 2'b00,
        SRC_CODER    = 2'b01,
        SRC_ENV_PIN  = 2'b10,
        SRC_HIGH     = 2'b11
    } driver_source_t;

    localparam logic [3:0] SIGNAL_OUTPUT_PIN_TRISTATE = 4'h0;
    localparam logic [3:0] SIGNAL_OUTPUT_PIN_LOW      = 4'h1;
    localparam logic [3:0] SIGNAL_OUTPUT_PIN_HIGH     = 4'h2;
    localparam logic [3:0] SIGNAL_OUTPUT_PIN_TEST     = 4'h3;
    localparam logic [3:0] SIGNAL_OUTPUT_PIN_ENVELOPE = 4'h4;
    localparam logic [3:0] SIGNAL_OUTPUT_PIN_SERIAL   = 4'h5;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLOCK_MHZ     = 250;
    localparam int ACTIVE_DELAY_NS  = 1000;
    localparam int INITIAL_DELAY_NS = 4000;
    localparam int ACTIVE_DELAY_CYCLES  = (ACTIVE_DELAY_NS * CLOCK_MHZ + 999) / 1000;
    localparam int INITIAL_DELAY_CYCLES = (INITIAL_DELAY_NS * CLOCK_MHZ + 999) / 1000;
    localparam int COLLISION_WAIT_N  = 3;
    localparam int DELAY_WIDTH = 16;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_FIELD   = 2'b01,
        ST_WAIT    = 2'b10,
        ST_ON      = 2'b11
    } auto_state_t;

endpackage

// file: rtl/sync_two_flop.sv
// Purpose: Two flip-flop level synchroniser for pin inputs
// Assumes: Input changes slower than the clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// file: rtl/driver_output_mux.sv
// Purpose: Builds one antenna driver level from the selected source
// Assumes: Inputs already in the pclk domain
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ps
module driver_output_mux
    import antenna_pkg::*;
(
    input  wire antenna_pkg::driver_source_t source,
    input  wire logic                        driver_on,
    input  wire logic                        invert_on,
    input  wire logic                        invert_off,
    input  wire logic                        coder_envelope,
    input  wire logic                        envelope_pin,
    input  wire logic                        full_depth,
    output logic                             level,
    output logic                             enable
);
    logic raw;

    always_comb begin
        raw    = 1'b0;
        enable = 1'b1;
        case (source)
            SRC_TRISTATE: enable = 1'b0;
            SRC_CODER:    raw = coder_envelope | ~full_depth & 1'b0;
            SRC_ENV_PIN:  raw = envelope_pin;
            SRC_HIGH:     raw = 1'b1;
            default:      enable = 1'b0;
        endcase
        // Inversion picks the on or off setting by driver state
        level = (driver_on ? raw ^ invert_on : raw ^ invert_off) & driver_on
              | (~driver_on & invert_off);
    end
endmodule

// file: rtl/antenna_driver_auto_control.sv
// Purpose: APB register bank and automatic carrier control for two antenna drivers
// Assumes: Field detector, tx done and envelopes come from outside; pins synchronised here
// Notes:   Slave answers in the access cycle, zero wait states
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps

// Behaviour
// - With auto field-off set, both enabled drivers turn off when the last bit has gone out; here only from ST_ON, not while waiting again after a new field.
// - With full-depth keying set, 100% keying is applied whatever depth is programmed.
// - With field wake set, soft power-down ends as soon as a field is detected.
// - The collision-avoid bit activates collision avoidance with the wait n preset.
// - The initial check bit runs initial avoidance and clears itself when our carrier turns on.
// - Driver-2 auto-enable turns driver 2 on a TADT after the external field goes away.
// - With initial check too, driver 2 turns on only after a field-free TIDT.
// - Driver-1 auto-enable governs driver 1 in the same way as driver 2.
// - The driver source field selects tristate, coder envelope, envelope pin or high.
// - In soft power-down drivers tristate only when the source is the tristate code.
// - With the high source each driver level follows its on and off inversion bits.
// - Source select resets to 10h and auto control to 00h.
// - The signal output select field chooses the signal output pin source.
module antenna_driver_auto_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        field_detect,
    input  wire logic        envelope_input_pin,
    input  wire logic        test_bus,
    input  wire logic        coder_envelope,
    input  wire logic        serial_stream,
    input  wire logic        tx_last_bit_done,
    input  wire logic        soft_power_down,
    output logic             wake_request,
    output logic             full_depth_keying,
    output logic             collision_avoid_on,
    output logic [1:0]       collision_wait_n,
    output logic             first_antenna_driver,
    output logic             first_antenna_driver_oe,
    output logic             second_antenna_driver,
    output logic             second_antenna_driver_oe,
    output logic             signal_output_pin,
    output logic             signal_output_pin_oe
);
    import antenna_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]        auto_control;
    logic [7:0]        source_select;
    logic [7:0]        driver_control;
    logic [1:0]        driver_on;
    auto_state_t       state;
    logic [DELAY_WIDTH-1:0] delay_count;
    logic [7:0]        next_auto_control;
    logic [7:0]        next_source_select;
    logic [7:0]        next_driver_control;
    logic [1:0]        next_driver_on;
    auto_state_t       next_state;
    logic [DELAY_WIDTH-1:0] next_delay_count;
    logic [31:0]       next_prdata;
    logic              next_pslverr;
    logic              field_sync;
    logic              env_sync;
    logic              d1_level;
    logic              d1_enable;
    logic              d2_level;
    logic              d2_enable;
    logic              next_sig_level;
    logic              next_sig_oe;
    logic              write_now;
    logic              read_now;
    logic              hit;
    logic              carrier_turn_on;

    function automatic logic addr_hit(input logic [11:0] addr);
        return addr == AUTO_CONTROL_ADDR || addr == SOURCE_SELECT_ADDR ||
               addr == DRIVER_CONTROL_ADDR || addr == STATUS_ADDR;
    endfunction

    sync_two_flop #(.WIDTH(2)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({field_detect, envelope_input_pin}),
        .sync_out ({field_sync, env_sync})
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign write_now = psel & penable & pwrite;
    assign read_now  = psel & penable & ~pwrite;
    assign hit       = addr_hit(paddr);

    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (psel & ~penable) begin
            next_pslverr = ~hit;
            if (!pwrite) begin
                case (paddr)
                    AUTO_CONTROL_ADDR:   next_prdata = {24'h0, auto_control};
                    SOURCE_SELECT_ADDR:  next_prdata = {24'h0, source_select};
                    DRIVER_CONTROL_ADDR: next_prdata = {24'h0, driver_control};
                    STATUS_ADDR:         next_prdata = {28'h0, state, driver_on};
                    default:             next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Automatic carrier sequencing
    // ------------------------------------------------------------------
    // Off until the field drops, then wait TADT (or TIDT for the initial check)
    always_comb begin
        next_state       = state;
        next_delay_count = delay_count;
        next_driver_on   = driver_on;
        carrier_turn_on  = 1'b0;
        case (state)
            ST_IDLE: begin
                if (auto_control[DRIVER1_AUTO_BIT] | auto_control[DRIVER2_AUTO_BIT]) begin
                    next_state       = field_sync ? ST_FIELD : ST_WAIT;
                    next_delay_count = '0;
                end
            end
            ST_FIELD: begin
                next_delay_count = '0;
                if (!field_sync) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (field_sync) begin
                    next_state       = ST_FIELD;
                    next_delay_count = '0;
                end else if (delay_count + 1'b1 >= DELAY_WIDTH'(
                        auto_control[INITIAL_CHECK_BIT] ? INITIAL_DELAY_CYCLES
                                                        : ACTIVE_DELAY_CYCLES)) begin
                    next_state      = ST_ON;
                    carrier_turn_on = 1'b1;
                    next_driver_on  = driver_on | {auto_control[DRIVER2_AUTO_BIT],
                                                   auto_control[DRIVER1_AUTO_BIT]};
                end else begin
                    next_delay_count = delay_count + 1'b1;
                end
            end
            ST_ON: begin
                if (auto_control[AUTO_FIELD_OFF_BIT] & tx_last_bit_done) begin
                    next_driver_on = 2'b00;
                    next_state     = ST_IDLE;
                end else if (field_sync) begin
                    // A new remote field re-arms the wait so a newly enabled driver can follow
                    next_state       = ST_FIELD;
                    next_delay_count = '0;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (!(auto_control[DRIVER1_AUTO_BIT] | auto_control[DRIVER2_AUTO_BIT]) &&
            state != ST_ON) begin
            next_state = ST_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_comb begin
        next_auto_control   = auto_control;
        next_source_select  = source_select;
        next_driver_control = driver_control;
        if (write_now && paddr == AUTO_CONTROL_ADDR) begin
            next_auto_control = pwdata[7:0] & AUTO_CONTROL_MASK;
        end
        if (write_now && paddr == SOURCE_SELECT_ADDR) begin
            next_source_select = pwdata[7:0] & SOURCE_SELECT_MASK;
        end
        if (write_now && paddr == DRIVER_CONTROL_ADDR) begin
            next_driver_control = pwdata[7:0];
        end
        // Self clear beats a same-cycle software write of the bit
        if (carrier_turn_on) begin
            next_auto_control[INITIAL_CHECK_BIT] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    driver_output_mux u_mux1 (
        .source         (driver_source_t'(source_select[5:4])),
        .driver_on      (driver_on[0]),
        .invert_on      (driver_control[INV1_ON_BIT]),
        .invert_off     (driver_control[INV1_OFF_BIT]),
        .coder_envelope (coder_envelope),
        .envelope_pin   (env_sync),
        .full_depth     (auto_control[FORCE_FULL_DEPTH_BIT]),
        .level          (d1_level),
        .enable         (d1_enable)
    );

    driver_output_mux u_mux2 (
        .source         (driver_source_t'(source_select[5:4])),
        .driver_on      (driver_on[1]),
        .invert_on      (driver_control[INV2_ON_BIT]),
        .invert_off     (driver_control[INV2_OFF_BIT]),
        .coder_envelope (coder_envelope),
        .envelope_pin   (env_sync),
        .full_depth     (auto_control[FORCE_FULL_DEPTH_BIT]),
        .level          (d2_level),
        .enable         (d2_enable)
    );

    always_comb begin
        next_sig_level = 1'b0;
        next_sig_oe    = 1'b1;
        case (source_select[3:0])
            SIGNAL_OUTPUT_PIN_TRISTATE: next_sig_oe = 1'b0;
            SIGNAL_OUTPUT_PIN_LOW:      next_sig_level = 1'b0;
            SIGNAL_OUTPUT_PIN_HIGH:     next_sig_level = 1'b1;
            SIGNAL_OUTPUT_PIN_TEST:     next_sig_level = test_bus;
            SIGNAL_OUTPUT_PIN_ENVELOPE: next_sig_level = coder_envelope;
            SIGNAL_OUTPUT_PIN_SERIAL:   next_sig_level = serial_stream;
            default:         next_sig_oe = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_control   <= AUTO_CONTROL_RESET;
            source_select  <= SOURCE_SELECT_RESET;
            driver_control <= DRIVER_CONTROL_RESET;
            driver_on      <= 2'b00;
            state          <= ST_IDLE;
            delay_count    <= '0;
            prdata         <= 32'h0000_0000;
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            wake_request   <= 1'b0;
            full_depth_keying        <= 1'b0;
            collision_avoid_on       <= 1'b0;
            collision_wait_n         <= 2'b00;
            first_antenna_driver     <= 1'b0;
            first_antenna_driver_oe  <= 1'b0;
            second_antenna_driver    <= 1'b0;
            second_antenna_driver_oe <= 1'b0;
            signal_output_pin        <= 1'b0;
            signal_output_pin_oe     <= 1'b0;
        end else begin
            auto_control   <= next_auto_control;
            source_select  <= next_source_select;
            driver_control <= next_driver_control;
            driver_on      <= next_driver_on;
            state          <= next_state;
            delay_count    <= next_delay_count;
            prdata         <= next_prdata;
            pready         <= psel & ~penable;
            pslverr        <= next_pslverr;
            wake_request   <= soft_power_down & auto_control[FIELD_WAKE_BIT]
                            & field_sync;
            full_depth_keying  <= auto_control[FORCE_FULL_DEPTH_BIT];
            collision_avoid_on <= auto_control[COLLISION_AVOID_BIT];
            collision_wait_n   <= 2'(COLLISION_WAIT_N);
            first_antenna_driver     <= d1_level;
            first_antenna_driver_oe  <= d1_enable;
            second_antenna_driver    <= d2_level;
            second_antenna_driver_oe <= d2_enable;
            signal_output_pin        <= next_sig_level;
            signal_output_pin_oe     <= next_sig_oe;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_field_off_done: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_ON && auto_control[AUTO_FIELD_OFF_BIT] && tx_last_bit_done
        |=> driver_on == 2'b00) else $error("drivers stayed on after last bit");
    a_wake_on_field: assert property (@(posedge pclk) disable iff (!presetn)
        soft_power_down && auto_control[FIELD_WAKE_BIT] && field_sync |=> wake_request)
        else $error("no wake on field");
    a_initial_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
        carrier_turn_on |=> !auto_control[INITIAL_CHECK_BIT])
        else $error("initial check bit not cleared");
    a_turn_on_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(driver_on[1]) |-> !$past(field_sync))
        else $error("driver turned on during field");
    a_tristate_src: assert property (@(posedge pclk) disable iff (!presetn)
        source_select[5:4] == 2'b00 |=> !first_antenna_driver_oe && !second_antenna_driver_oe)
        else $error("driver enabled with tristate source");
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        auto_control[4] == 1'b0 && source_select[7:6] == 2'b00)
        else $error("reserved bit set");
    a_full_depth: assert property (@(posedge pclk) disable iff (!presetn)
        auto_control[FORCE_FULL_DEPTH_BIT] |=> full_depth_keying)
        else $error("full depth not applied");
    a_signal_output_pin_high: assert property (@(posedge pclk) disable iff (!presetn)
        source_select[3:0] == SIGNAL_OUTPUT_PIN_HIGH |=> signal_output_pin && signal_output_pin_oe)
        else $error("signal output not high");
endmodule

// file: tb/field_source.sv
// Purpose: Behavioural remote field and envelope pin source
// Assumes: Bench commands the field level and envelope level
// Notes:   Pins follow the command one pclk later, like a slow analog front end
`timescale 1ns/1ps
module field_source (
    input  wire logic pclk,
    input  wire logic field_on,
    input  wire logic env,
    output logic      field_detect,
    output logic      envelope_input_pin
);
    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    always_ff @(posedge pclk) begin
        field_detect       <= field_on;
        envelope_input_pin <= env;
    end
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench for the antenna driver automatic control block
// Assumes: Zero wait state APB slave, TADT 250 and TIDT 1000 cycles
// Notes:   Far side field is modelled by field_source
`timescale 1ns/1ps
module tb;
    import antenna_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        field_detect, envelope_input_pin, test_bus, coder_envelope;
    logic        serial_stream, tx_last_bit_done, soft_power_down, wake_request;
    logic        full_depth_keying, collision_avoid_on, first_antenna_driver;
    logic        first_antenna_driver_oe, second_antenna_driver, second_antenna_driver_oe;
    logic        signal_output_pin, signal_output_pin_oe, field_on, env;
    logic [1:0]  collision_wait_n;
    int          num_errors, comparisons, n;

    antenna_driver_auto_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .field_detect, .envelope_input_pin,
        .test_bus, .coder_envelope, .serial_stream, .tx_last_bit_done, .soft_power_down,
        .wake_request, .full_depth_keying, .collision_avoid_on, .collision_wait_n,
        .first_antenna_driver, .first_antenna_driver_oe, .second_antenna_driver,
        .second_antenna_driver_oe, .signal_output_pin, .signal_output_pin_oe);
    field_source i_far (.pclk, .field_on, .env, .field_detect, .envelope_input_pin);

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input string w, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", w, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16) begin
            num_errors++;
            give_verdict();
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string w);
        apb(1'b0, a, 32'h0);
        chk(w, q, e);
    endtask
    task settle;
        repeat (6) @(posedge pclk);
    endtask
    // Cycles until the chosen driver turns on; bounded so a dead timer ends the run
    task wait_on(input logic second);
        n = 0;
        while ((second ? second_antenna_driver : first_antenna_driver) !== 1'b1) begin
            @(posedge pclk);
            n++;
            if (n > 2000) begin
                num_errors++;
                give_verdict();
            end
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        rd(AUTO_CONTROL_ADDR, 32'h0, "auto reset");
        rd(SOURCE_SELECT_ADDR, 32'h10, "source reset");
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped err", err, 1);
        apb(1'b1, AUTO_CONTROL_ADDR, 32'hffff_ff10);
        rd(AUTO_CONTROL_ADDR, 32'h0, "auto reserved");
        apb(1'b1, SOURCE_SELECT_ADDR, 32'hffff_ffd0);
        rd(SOURCE_SELECT_ADDR, 32'h10, "source reserved");
        $display("test regs done");
    endtask
    task t_auto_on;
        apb(1'b1, DRIVER_CONTROL_ADDR, 32'h0);
        apb(1'b1, SOURCE_SELECT_ADDR, 32'h30);
        apb(1'b1, AUTO_CONTROL_ADDR, 32'h05);
        wait_on(1'b0);
        chk("tidt wait", n >= 1000 && n <= 1012, 1);
        rd(AUTO_CONTROL_ADDR, 32'h01, "initial self clear");
        apb(1'b1, AUTO_CONTROL_ADDR, 32'h82);
        field_on <= 1'b1;
        repeat (300) @(posedge pclk);
        chk("drv2 held off", second_antenna_driver, 0);
        field_on <= 1'b0;
        wait_on(1'b1);
        chk("tadt wait", n >= 250 && n <= 262, 1);
        $display("test auto on done");
    endtask
    task t_sources;
        apb(1'b1, DRIVER_CONTROL_ADDR, 32'hc0);
        settle();
        chk("high inv 1", first_antenna_driver, 0);
        chk("high inv 2", second_antenna_driver, 0);
        apb(1'b1, DRIVER_CONTROL_ADDR, 32'h0);
        settle();
        chk("high 2", second_antenna_driver, 1);
        for (int s = 1; s < 3; s++) begin
            for (int v = 0; v < 2; v++) begin
                apb(1'b1, SOURCE_SELECT_ADDR, s << 4);
                @(posedge pclk);
                coder_envelope <= v[0];
                env <= ~v[0];
                settle();
                chk("source level", first_antenna_driver, (s == 1) ? v : !v);
            end
        end
        apb(1'b1, SOURCE_SELECT_ADDR, 32'h0);
        soft_power_down <= 1'b1;
        settle();
        chk("tristate oe", second_antenna_driver_oe, 0);
        apb(1'b1, SOURCE_SELECT_ADDR, 32'h10);
        settle();
        chk("power down oe", first_antenna_driver_oe, 1);
        soft_power_down <= 1'b0;
        @(posedge pclk);
        tx_last_bit_done <= 1'b1;
        @(posedge pclk);
        tx_last_bit_done <= 1'b0;
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk("auto off", q[1:0], 0);
        $display("test sources done");
    endtask
    task t_misc;
        apb(1'b1, AUTO_CONTROL_ADDR, 32'h68);
        soft_power_down <= 1'b1;
        field_on <= 1'b1;
        settle();
        chk("full depth", full_depth_keying, 1);
        chk("avoid on", {collision_avoid_on, collision_wait_n}, 3'h7);
        chk("wake", wake_request, 1);
        field_on <= 1'b0;
        settle();
        chk("no wake", wake_request, 0);
        // Both drivers are off here, so the off-state inversion sets the high level
        apb(1'b1, DRIVER_CONTROL_ADDR, 32'h30);
        apb(1'b1, SOURCE_SELECT_ADDR, 32'h30);
        settle();
        chk("high off inv 1", first_antenna_driver, 1);
        chk("high off inv 2", second_antenna_driver, 1);
        test_bus <= 1'b1;
        coder_envelope <= 1'b1;
        serial_stream <= 1'b0;
        for (int c = 0; c < 6; c++) begin
            apb(1'b1, SOURCE_SELECT_ADDR, c);
            settle();
            chk("signal_output_pin oe", signal_output_pin_oe, c != 0);
            if (c != 0) begin
                chk("signal_output_pin", signal_output_pin, 6'b011100 >> c & 1);
            end
        end
        $display("test misc done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {test_bus, coder_envelope, serial_stream, tx_last_bit_done} = '0;
        {soft_power_down, field_on, env} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_auto_on();
        t_sources();
        t_misc();
        give_verdict();
    end
endmodule
